// ==== hdl/adcrb_reg_bank.sv ====
// register bank for output interface and power-down control
`timescale 1ns/10ps
module adcrb_reg_bank #(
	parameter logic [2:0] FUSE_MODE = 3'h0,
	parameter logic [2:0] FUSE_MAP  = 3'h6,
	parameter int         DRV_W     = 24
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic [11:0] regAddr,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regWrEn,
	input  wire logic        regRdEn,
	output logic      [7:0]  regRdData,
	output logic      [2:0]  activeMode,
	output logic      [2:0]  activeMap,
	output logic             sampleClkBufOff,
	output logic             refAmpOff,
	output logic             channelAOff,
	output logic             wholeChipPowerdown,
	output logic [DRV_W-1:0] outputDriverOffMask,
	output logic             inputDataClockEn,
	output logic             outputDataClockOff,
	output logic             configLoading
);
	logic [7:0]       ifCfgQ;
	logic [7:0]       pwrQ;
	logic [DRV_W-1:0] drvOffQ;
	logic [7:0]       pdMaskQ;
	logic [7:0]       inClkAQ;
	logic [7:0]       clkCtrlQ;
	logic             mapWrittenQ;
	logic             softResetQ;
	logic             reloadQ;
	logic             clearRegs;
	logic [2:0]       mapLoaded;
	logic             loadBusy;

	initial begin
		if (DRV_W != 24)
			$error("driver vector must be 24 bits");
	end

	function automatic logic wrHit(input logic [11:0] ofs);
		wrHit = regWrEn && (regAddr == ofs);
	endfunction

	// soft reset wipes all written values, fuse reload all but the interface config
	assign clearRegs = softResetQ || reloadQ;

	// reset bit self clears one cycle after the write
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			softResetQ <= 1'b0;
		else
			softResetQ <= wrHit(adcrb_pkg::OfsSoftReset)
				&& regWrData[adcrb_pkg::SoftResetBit];
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			reloadQ <= 1'b0;
		else
			reloadQ <= wrHit(adcrb_pkg::OfsFuseReload)
				&& regWrData[adcrb_pkg::FuseReloadBit];
	end

	// interface config survives a fuse reload, which applies its bit map; only soft reset or rst_b clears it
	always_ff @(posedge sys_clk) begin
		if (!rst_b || softResetQ) begin
			ifCfgQ <= adcrb_pkg::IfConfigRst;
			mapWrittenQ <= 1'b0;
		end else if (wrHit(adcrb_pkg::OfsIfConfig)) begin
			ifCfgQ <= regWrData & adcrb_pkg::IfConfigWr;
			mapWrittenQ <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b || clearRegs)
			pwrQ <= adcrb_pkg::PowerDownRst;
		else if (wrHit(adcrb_pkg::OfsPowerDown))
			pwrQ <= (regWrData & adcrb_pkg::PowerDownWr)
				| adcrb_pkg::PowerDownFix;
	end

	// three byte registers form the driver-off vector
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gDrv
			always_ff @(posedge sys_clk) begin
				if (!rst_b || clearRegs)
					drvOffQ[g*8 +: 8] <= adcrb_pkg::RegRst;
				else if (wrHit(adcrb_pkg::OfsDrvOffLow + 12'(g)))
					drvOffQ[g*8 +: 8] <= regWrData;
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (!rst_b || clearRegs)
			pdMaskQ <= adcrb_pkg::RegRst;
		else if (wrHit(adcrb_pkg::OfsPdMask))
			pdMaskQ <= regWrData & adcrb_pkg::PdMaskWr;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b || clearRegs)
			inClkAQ <= adcrb_pkg::RegRst;
		else if (wrHit(adcrb_pkg::OfsInClkEnA))
			inClkAQ <= regWrData & adcrb_pkg::InClkAWr;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b || clearRegs)
			clkCtrlQ <= adcrb_pkg::RegRst;
		else if (wrHit(adcrb_pkg::OfsClkCtrl))
			clkCtrlQ <= regWrData & adcrb_pkg::ClkCtrlWr;
	end

	adcrb_fuse_load #(
		.FUSE_MODE (FUSE_MODE),
		.FUSE_MAP  (FUSE_MAP)
	) uLoad (
		.sys_clk    (sys_clk),
		.rst_b      (rst_b),
		.reloadReq  (reloadQ),
		.softReset  (softResetQ),
		.wrMap      (ifCfgQ[adcrb_pkg::BitMapLsb +: 3]),
		.wrMapValid (mapWrittenQ),
		.activeMap  (mapLoaded),
		.loadBusy   (loadBusy)
	);

	// registered outputs
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			activeMode <= FUSE_MODE;
			activeMap <= FUSE_MAP;
			configLoading <= 1'b1;
		end else begin
			activeMode <= ifCfgQ[adcrb_pkg::ChangeEnBit]
				? ifCfgQ[adcrb_pkg::ModeSelLsb +: 3]
				: FUSE_MODE;
			activeMap <= mapLoaded;
			configLoading <= loadBusy;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			sampleClkBufOff <= 1'b0;
			refAmpOff <= 1'b0;
			channelAOff <= 1'b0;
			wholeChipPowerdown <= 1'b0;
		end else begin
			sampleClkBufOff <= pwrQ[adcrb_pkg::SampleClkOffBit]
				|| (pwrQ[adcrb_pkg::WholeChipBit]
				&& !pdMaskQ[adcrb_pkg::KeepClkBufBit]);
			refAmpOff <= pwrQ[adcrb_pkg::RefAmpOffBit]
				|| (pwrQ[adcrb_pkg::WholeChipBit]
				&& !pdMaskQ[adcrb_pkg::KeepRefAmpBit]);
			channelAOff <= pwrQ[adcrb_pkg::ChanAOffBit]
				|| pwrQ[adcrb_pkg::WholeChipBit];
			wholeChipPowerdown <= pwrQ[adcrb_pkg::WholeChipBit];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			outputDriverOffMask <= '0;
			inputDataClockEn <= 1'b0;
			outputDataClockOff <= 1'b1;
		end else begin
			outputDriverOffMask <= drvOffQ;
			inputDataClockEn <= inClkAQ[adcrb_pkg::InClkEnABit]
				|| clkCtrlQ[adcrb_pkg::InClkEnBBit];
			outputDataClockOff <= !clkCtrlQ[adcrb_pkg::OutClkEnBit];
		end
	end

	// read data, zero for unmapped addresses
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			regRdData <= 8'h00;
		end else if (regRdEn) begin
			case (regAddr)
				adcrb_pkg::OfsIfConfig:   regRdData <= ifCfgQ;
				adcrb_pkg::OfsPowerDown:  regRdData <= pwrQ;
				adcrb_pkg::OfsDrvOffLow:  regRdData <= drvOffQ[7:0];
				adcrb_pkg::OfsDrvOffMid:  regRdData <= drvOffQ[15:8];
				adcrb_pkg::OfsDrvOffHigh: regRdData <= drvOffQ[23:16];
				adcrb_pkg::OfsPdMask:     regRdData <= pdMaskQ;
				adcrb_pkg::OfsInClkEnA:   regRdData <= inClkAQ;
				adcrb_pkg::OfsClkCtrl:    regRdData <= clkCtrlQ;
				default:                  regRdData <= 8'h00;
			endcase
		end
	end
endmodule

// ==== pkg/adcrb_pkg.sv ====
// constants for the output interface and power-down register bank
package adcrb_pkg;
	localparam logic [11:0] OfsSoftReset    = 12'h000;
	localparam logic [11:0] OfsIfConfig     = 12'h007;
	localparam logic [11:0] OfsPowerDown    = 12'h008;
	localparam logic [11:0] OfsDrvOffLow    = 12'h00a;
	localparam logic [11:0] OfsDrvOffMid    = 12'h00b;
	localparam logic [11:0] OfsDrvOffHigh   = 12'h00c;
	localparam logic [11:0] OfsPdMask       = 12'h00d;
	localparam logic [11:0] OfsFuseReload   = 12'h013;
	localparam logic [11:0] OfsInClkEnA     = 12'h018;
	localparam logic [11:0] OfsClkCtrl      = 12'h01f;
	// field positions
	localparam int BitMapLsb       = 5;
	localparam int ChangeEnBit     = 3;
	localparam int ModeSelLsb      = 0;
	localparam int SampleClkOffBit = 5;
	localparam int RefAmpOffBit    = 4;
	localparam int ChanAOffBit     = 2;
	localparam int WholeChipBit    = 0;
	localparam int KeepClkBufBit   = 3;
	localparam int KeepRefAmpBit   = 2;
	localparam int InClkEnABit     = 4;
	localparam int InClkEnBBit     = 6;
	localparam int OutClkEnBit     = 4;
	localparam int SoftResetBit    = 0;
	localparam int FuseReloadBit   = 0;
	// reset values, fixed bits and write masks
	localparam logic [7:0] IfConfigRst  = 8'h00;
	localparam logic [7:0] PowerDownRst = 8'h02;
	localparam logic [7:0] PowerDownFix = 8'h02;
	localparam logic [7:0] PowerDownWr  = 8'h35;
	localparam logic [7:0] IfConfigWr   = 8'hef;
	localparam logic [7:0] PdMaskWr     = 8'h2e;
	localparam logic [7:0] InClkAWr     = 8'h10;
	localparam logic [7:0] ClkCtrlWr    = 8'hd8;
	localparam logic [7:0] RegRst       = 8'h00;
	// bit-map variant codes
	localparam logic [2:0] MapTwoWire18 = 3'h1;
	localparam logic [2:0] MapTwoWire16 = 3'h2;
	localparam logic [2:0] MapOneWire   = 3'h3;
	localparam logic [2:0] MapHalfWire  = 3'h4;
	localparam logic [2:0] MapDdr       = 3'h5;
	localparam logic [2:0] MapSdr       = 3'h6;
	// interface mode codes
	localparam logic [2:0] ModeSdr      = 3'h0;
	localparam logic [2:0] ModeDdr      = 3'h1;
	localparam logic [2:0] ModeTwoWire  = 3'h3;
	localparam logic [2:0] ModeOneWire  = 3'h4;
	localparam logic [2:0] ModeHalfWire = 3'h5;
	// load sequencer states
	typedef enum logic [2:0] {
		LdIdle = 3'b001,
		LdLoad = 3'b010,
		LdDone = 3'b100
	} adcrb_load_t;
endpackage

// ==== hdl/adcrb_fuse_load.sv ====
// fuse-load sequencer: applies the bit map only, not the interface mode
`timescale 1ns/10ps
module adcrb_fuse_load #(
	parameter logic [2:0] FUSE_MODE = 3'h0,
	parameter logic [2:0] FUSE_MAP  = 3'h6
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic       reloadReq,
	input  wire logic       softReset,
	input  wire logic [2:0] wrMap,
	input  wire logic       wrMapValid,
	output logic      [2:0] activeMap,
	output logic            loadBusy
);
	adcrb_pkg::adcrb_load_t stateQ;

	initial begin
		if (FUSE_MAP == 3'h0 || FUSE_MAP == 3'h7)
			$error("fuse bit map code not a valid variant");
		if (FUSE_MODE == 3'h2 || FUSE_MODE > 3'h5)
			$error("fuse mode code not a valid mode");
	end

	// sequencer: reset or reload command walks through a load cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_b || softReset) begin
			stateQ <= adcrb_pkg::LdLoad;
		end else begin
			case (stateQ)
				adcrb_pkg::LdIdle: begin
					if (reloadReq)
						stateQ <= adcrb_pkg::LdLoad;
				end
				adcrb_pkg::LdLoad: stateQ <= adcrb_pkg::LdDone;
				adcrb_pkg::LdDone: stateQ <= adcrb_pkg::LdIdle;
				default: stateQ <= adcrb_pkg::LdIdle;
			endcase
		end
	end

	// bit map comes only through the load path
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			activeMap <= FUSE_MAP;
		end else if (stateQ == adcrb_pkg::LdLoad) begin
			activeMap <= wrMapValid ? wrMap : FUSE_MAP;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			loadBusy <= 1'b1;
		else
			loadBusy <= (stateQ != adcrb_pkg::LdIdle) || softReset;
	end
endmodule

// ==== testbench/adcrb_host.sv ====
// host controller model on the register port
`timescale 1ns/10ps
module adcrb_host (
	input  wire logic        sys_clk,
	output logic      [11:0] regAddr,
	output logic      [7:0]  regWrData,
	output logic             regWrEn,
	output logic             regRdEn
);
	initial begin
		regAddr = 12'h000;
		regWrData = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
	end
	// one-cycle strobe, released lines show the inverse
	task automatic acc(input logic [11:0] a, input logic [7:0] d, input logic w);
		@(posedge sys_clk);
		#1;
		regAddr = a;
		regWrData = d;
		regWrEn = w;
		regRdEn = !w;
		@(posedge sys_clk);
		#1;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
	endtask
endmodule

// ==== testbench/adcrb_reg_bank_sva.sv ====
// port assertions for the register bank
`timescale 1ns/10ps
module adcrb_reg_bank_sva #(
	parameter logic [2:0] FUSE_MODE = 3'h0,
	parameter int         DRV_W     = 24
) (
	input wire logic             sys_clk,
	input wire logic             rst_b,
	input wire logic [11:0]      regAddr,
	input wire logic [7:0]       regWrData,
	input wire logic             regWrEn,
	input wire logic             regRdEn,
	input wire logic [7:0]       regRdData,
	input wire logic [2:0]       activeMode,
	input wire logic [2:0]       activeMap,
	input wire logic             sampleClkBufOff,
	input wire logic             channelAOff,
	input wire logic             wholeChipPowerdown,
	input wire logic [DRV_W-1:0] outputDriverOffMask,
	input wire logic             configLoading
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	wire logic wrPd = regWrEn && regAddr == adcrb_pkg::OfsPowerDown;
	wire logic wrIf = regWrEn && regAddr == adcrb_pkg::OfsIfConfig;
	clk_buf_off_a: assert property (wrPd && !regWrData[0] |-> ##2
		sampleClkBufOff == $past(regWrData[5], 2)) else $error("clkbuf off");
	chan_a_off_a: assert property (wrPd |-> ##2
		channelAOff == $past(regWrData[2] | regWrData[0], 2)) else $error("chan a");
	whole_chip_a: assert property (wrPd |-> ##2
		wholeChipPowerdown == $past(regWrData[0], 2)) else $error("global pd");
	drv_low_a: assert property (regWrEn && regAddr == adcrb_pkg::OfsDrvOffLow |-> ##2
		outputDriverOffMask[7:0] == $past(regWrData, 2)) else $error("drv low");
	mode_sel_a: assert property (wrIf && regWrData[3] |-> ##2
		activeMode == $past(regWrData[2:0], 2)) else $error("mode sel");
	mode_fuse_a: assert property (wrIf && !regWrData[3] |-> ##2
		activeMode == FUSE_MODE) else $error("mode fuse");
	map_hold_a: assert property ($changed(activeMap) |->
		(configLoading || $past(configLoading))) else $error("map moved");
	rd_mid_a: assert property (regRdEn && regAddr == adcrb_pkg::OfsDrvOffMid |=>
		regRdData == outputDriverOffMask[15:8]) else $error("rd mid");
	soft_rst_a: assert property (regWrEn && regAddr == 12'h000 && regWrData[0] |->
		##[2:6] outputDriverOffMask == '0 && !wholeChipPowerdown) else $error("sw reset");
	cover property (wrPd && regWrData[0]);
	cover property (configLoading ##1 !configLoading);
	cover property (wrIf && regWrData[3]);
endmodule
bind adcrb_reg_bank adcrb_reg_bank_sva #(.FUSE_MODE(FUSE_MODE), .DRV_W(DRV_W)) u_sva (.*);

// ==== testbench/tb.sv ====
// self-checking bench for the register bank
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
	localparam logic [2:0] FM = 3'h0;
	localparam logic [2:0] FP = 3'h6;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [11:0] regAddr;
	logic [7:0]  regWrData, regRdData, ex, v, m;
	logic        regWrEn, regRdEn, rdP1, rdP2;
	logic [2:0]  activeMode, activeMap, cm;
	logic        sampleClkBufOff, refAmpOff, channelAOff, wholeChipPowerdown;
	logic        inputDataClockEn, outputDataClockOff, configLoading;
	logic [23:0] outputDriverOffMask, dv;
	logic [7:0]  q[$];
	logic [2:0]  mt[5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
	logic [31:0] seed = 32'h0155adc7;
	int          mismatches = 0;
	int          compares = 0;
	always #10 sys_clk = ~sys_clk;
	adcrb_host host (.*);
	adcrb_reg_bank #(.FUSE_MODE(FM), .FUSE_MAP(FP)) dut (.*);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		host.acc(a, d, 1'b1);
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		q.push_back(e);
		host.acc(a, 8'h00, 1'b0);
	endtask
	task automatic settle();
		int n;
		n = 0;
		repeat (3) @(posedge sys_clk);
		while (configLoading !== 1'b0 && n < 40) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 40) begin
			mismatches++;
			close_out();
		end
		#1;
	endtask
	always @(posedge sys_clk) begin
		rdP1 <= regRdEn;
		rdP2 <= rdP1;
	end
	always @(negedge sys_clk) begin
		if (rdP2 === 1'b1) begin
			ex = q.pop_front();
			`CHK(regRdData, ex)
		end
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		settle();
		`CHK(activeMode, FM)
		`CHK(activeMap, FP)
		`CHK(outputDataClockOff, 1'b1)
		rd(adcrb_pkg::OfsIfConfig, 8'h00);
		rd(adcrb_pkg::OfsPowerDown, 8'h02);
		$display("reset test done");
		cm = FP;
		for (int i = 1; i < 7; i++) begin
			v = {3'(i), 2'b01, mt[i % 5]};
			wr(adcrb_pkg::OfsIfConfig, v);
			`CHK(activeMode, mt[i % 5])
			`CHK(activeMap, cm)
			wr(adcrb_pkg::OfsFuseReload, 8'h01);
			settle();
			cm = 3'(i);
			`CHK(activeMap, cm)
			rd(adcrb_pkg::OfsIfConfig, v);
		end
		wr(adcrb_pkg::OfsIfConfig, 8'h03);
		`CHK(activeMode, FM)
		$display("interface test done");
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			m = seed[15:8] & 8'h2e;
			v = (seed[7:0] & 8'h34) | 8'h02 | 8'(i % 2);
			wr(adcrb_pkg::OfsPdMask, m);
			wr(adcrb_pkg::OfsPowerDown, v);
			`CHK(sampleClkBufOff, v[5] | (v[0] & ~m[3]))
			`CHK(refAmpOff, v[4] | (v[0] & ~m[2]))
			`CHK(channelAOff, v[2] | v[0])
			`CHK(wholeChipPowerdown, v[0])
			rd(adcrb_pkg::OfsPowerDown, v);
		end
		$display("power-down test done");
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			dv = seed[23:0] | 24'h000008;
			wr(adcrb_pkg::OfsDrvOffLow, dv[7:0]);
			wr(adcrb_pkg::OfsDrvOffMid, dv[15:8]);
			wr(adcrb_pkg::OfsDrvOffHigh, dv[23:16]);
			`CHK(outputDriverOffMask, dv)
			rd(adcrb_pkg::OfsDrvOffMid, dv[15:8]);
		end
		wr(adcrb_pkg::OfsInClkEnA, 8'h10);
		`CHK(inputDataClockEn, 1'b1)
		wr(adcrb_pkg::OfsClkCtrl, 8'h10);
		`CHK(outputDataClockOff, 1'b0)
		`CHK(outputDriverOffMask, dv)
		wr(adcrb_pkg::OfsInClkEnA, 8'h00);
		wr(adcrb_pkg::OfsClkCtrl, 8'h40);
		`CHK(inputDataClockEn, 1'b1)
		`CHK(outputDataClockOff, 1'b1)
		$display("clock enable test done");
		rd(12'h0ff, 8'h00);
		wr(adcrb_pkg::OfsSoftReset, 8'h01);
		settle();
		`CHK(outputDriverOffMask, 24'h000000)
		`CHK(inputDataClockEn, 1'b0)
		rd(adcrb_pkg::OfsSoftReset, 8'h00);
		rd(adcrb_pkg::OfsIfConfig, 8'h00);
		repeat (3) @(posedge sys_clk);
		$display("soft reset test done");
		close_out();
	end
endmodule
